/* File: src/vfk_top.v */
// Key scanner, serial slave port, standby and display cycle timing
`timescale 1ns/1ps
`include "vfk_regs.vh"
module vfk_top #(
    parameter ROW_CYCLES = (`VFK_SCAN_NS / `VFK_ROWS) / `VFK_CLK_NS,
    parameter PAIR_CYCLES = (`VFK_PAIR_OSC * `VFK_OSC_NS) / `VFK_CLK_NS,
    parameter BLANK_CYCLES = (`VFK_BLANK_OSC * `VFK_OSC_NS + `VFK_CLK_NS - 1) / `VFK_CLK_NS
) (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // Serial host port
    input wire sel_n,
    input wire sclk,
    input wire sdi,
    output reg sdo_out,
    output reg sdo_oe,
    // Key matrix
    input wire [5:0] key_column_in,
    output reg [4:0] key_row_out,
    output reg key_event_irq_n,
    // Grid driver and display settings
    output reg standby_out,
    output reg [9:0] dim_value_out,
    output reg [4:0] digit_pairs_out,
    output reg display_blank_out
);

// ********************************
// Input synchronisers
// ********************************
wire [8:0] pins_s;
reg sclk_d_reg;
reg sel_d_reg;

vfk_sync #(.W(9), .RST_VAL(9'h1ff)) u_sync (
    .clock(clock),
    .rstn(rstn),
    .din({sdi, sel_n, sclk, key_column_in}),
    .dout(pins_s)
);

wire [5:0] col_s = pins_s[5:0];
wire sclk_s = pins_s[6];
wire sel_s = pins_s[7];
wire sdi_s = pins_s[8];
wire sclk_rise = sclk_s & ~sclk_d_reg;
wire sclk_fall = ~sclk_s & sclk_d_reg;
wire sel_fall = ~sel_s & sel_d_reg;
wire sel_rise = sel_s & ~sel_d_reg;
wire active = ~sel_s;

// ********************************
// Serial port state
// ********************************
reg [2:0] bit_cnt_reg;
reg [7:0] rx_reg;
reg [7:0] cmd_reg;
reg cmd_valid_reg;
reg [2:0] byte_idx_reg;
reg [7:0] tx_reg;
reg [2:0] dbyte_reg;
reg pending_reg;
reg [29:0] key_data_reg;

wire [7:0] rx_byte = {rx_reg[6:0], sdi_s};
wire byte_done = active & sclk_rise & (bit_cnt_reg == 3'h7);
wire cmd_reads = (rx_byte == `VFK_CMD_READOUT) | (rx_byte == `VFK_CMD_NULL);
wire keep_reads = (cmd_reg == `VFK_CMD_READOUT) | (cmd_reg == `VFK_CMD_NULL);
wire [7:0] status_byte = pending_reg ? `VFK_STATUS_NEW : `VFK_STATUS_NONE;
wire readout_done = sel_rise & cmd_valid_reg & (cmd_reg == `VFK_CMD_READOUT);

reg [2:0] next_idx;
reg [7:0] next_tx;
reg [5:0] row_byte;

always @* begin
    next_idx = 3'h0;
    if (byte_idx_reg != 3'h5) begin
        next_idx = byte_idx_reg + 3'h1;
    end
    row_byte = key_data_reg[6*byte_idx_reg +: 6];
    next_tx = status_byte;
    if (byte_idx_reg == 3'h0) begin
        if (cmd_reads) begin
            next_tx = {2'b00, key_data_reg[5:0]};
        end
    end else if (keep_reads && (byte_idx_reg != 3'h5)) begin
        next_tx = {2'b00, key_data_reg[6*next_idx - 6 +: 6]};
    end
end

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        sclk_d_reg <= 1'b1;
        sel_d_reg <= 1'b1;
        bit_cnt_reg <= 3'h0;
        rx_reg <= 8'h00;
        cmd_reg <= 8'h00;
        cmd_valid_reg <= 1'b0;
        byte_idx_reg <= 3'h0;
        dbyte_reg <= 3'h0;
        tx_reg <= 8'hff;
        sdo_out <= 1'b1;
        sdo_oe <= 1'b0;
    end else begin
        sclk_d_reg <= sclk_s;
        sel_d_reg <= sel_s;
        sdo_oe <= active;
        if (!active) begin
            bit_cnt_reg <= 3'h0;
            byte_idx_reg <= 3'h0;
            dbyte_reg <= 3'h0;
        end
        if (sel_rise) begin
            cmd_valid_reg <= 1'b0;
        end
        if (sel_fall) begin
            tx_reg <= status_byte;
            sdo_out <= status_byte[7];
        end else if (active && sclk_fall) begin
            sdo_out <= tx_reg[~bit_cnt_reg];
        end
        if (active && sclk_rise) begin
            rx_reg <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
        if (byte_done) begin
            byte_idx_reg <= next_idx;
            tx_reg <= next_tx;
            if (!cmd_valid_reg) begin
                cmd_reg <= rx_byte;
                cmd_valid_reg <= 1'b1;
            end else if (dbyte_reg != 3'h7) begin
                dbyte_reg <= dbyte_reg + 3'h1;
            end
        end
    end
end

// ********************************
// Command execution
// ********************************
reg standby_reg;
reg start_scan;

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        standby_reg <= 1'b0;
        standby_out <= 1'b0;
        dim_value_out <= `VFK_DIM_RST;
        digit_pairs_out <= `VFK_DIGITS_RST;
    end else begin
        standby_out <= standby_reg;
        if (sel_fall || start_scan) begin
            standby_reg <= 1'b0;
        end else if (byte_done && cmd_valid_reg && (cmd_reg == `VFK_CMD_MODE)) begin
            standby_reg <= rx_byte[`VFK_MODE_STBY_BIT];
        end
        if (byte_done && cmd_valid_reg && (cmd_reg == `VFK_CMD_DIM)) begin
            if (dbyte_reg == 3'h0) begin
                dim_value_out[9:8] <= rx_byte[1:0];
            end else if (dbyte_reg == 3'h1) begin
                dim_value_out[7:0] <= rx_byte;
            end
        end
        if (byte_done && cmd_valid_reg && (cmd_reg == `VFK_CMD_DIGITS)) begin
            digit_pairs_out <= {1'b0, rx_byte[3:0]} + 5'h01;
        end
    end
end

// ********************************
// Key scanner
// ********************************
reg scanning_reg;
reg [2:0] row_idx_reg;
reg [15:0] slot_cnt_reg;
reg [29:0] scan_buf_reg;
reg [2:0] settle_reg;
reg [5:0] ref_cols;
integer i;

wire [5:0] pressed = ~col_s;
wire slot_end = scanning_reg & (slot_cnt_reg == ROW_CYCLES - 1);
wire cycle_end = slot_end & (row_idx_reg == 3'h4);
wire [29:0] new_data = {pressed, scan_buf_reg[23:0]};
wire set_irq = cycle_end & ~pending_reg & (new_data != key_data_reg);

always @* begin
    ref_cols = 6'h00;
    for (i = 0; i < 5; i = i + 1) begin
        ref_cols = ref_cols | key_data_reg[6*i +: 6];
    end
    start_scan = ~scanning_reg & (settle_reg == `VFK_SETTLE_CYC) & (pressed != ref_cols);
end

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        scanning_reg <= 1'b0;
        row_idx_reg <= 3'h0;
        slot_cnt_reg <= 16'h0000;
        scan_buf_reg <= 30'h0;
        settle_reg <= 3'h0;
        key_data_reg <= 30'h0;
        pending_reg <= 1'b0;
        key_row_out <= 5'h00;
        key_event_irq_n <= 1'b1;
    end else begin
        if (scanning_reg || start_scan) begin
            settle_reg <= 3'h0;
        end else if (settle_reg != `VFK_SETTLE_CYC) begin
            settle_reg <= settle_reg + 3'h1;
        end
        if (start_scan) begin
            scanning_reg <= 1'b1;
            row_idx_reg <= 3'h0;
            slot_cnt_reg <= 16'h0000;
        end else if (slot_end) begin
            slot_cnt_reg <= 16'h0000;
            scan_buf_reg[6*row_idx_reg +: 6] <= pressed;
            if (row_idx_reg == 3'h4) begin
                row_idx_reg <= 3'h0;
                if (!pending_reg && !set_irq) begin
                    scanning_reg <= 1'b0;
                end
            end else begin
                row_idx_reg <= row_idx_reg + 3'h1;
            end
        end else if (scanning_reg) begin
            slot_cnt_reg <= slot_cnt_reg + 16'h0001;
        end
        if (set_irq) begin
            key_data_reg <= new_data;
            pending_reg <= 1'b1;
        end else if (readout_done) begin
            pending_reg <= 1'b0;
            scanning_reg <= 1'b0;
        end
        key_event_irq_n <= ~(pending_reg | set_irq);
        if (scanning_reg && !(readout_done && !set_irq)) begin
            key_row_out <= ~(5'h01 << row_idx_reg);
        end else begin
            key_row_out <= 5'h00;
        end
    end
end

// ********************************
// Display cycle and blanking
// ********************************
reg [15:0] disp_cnt_reg;
reg [4:0] pair_cnt_reg;
reg blank_reg;

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        disp_cnt_reg <= 16'h0000;
        pair_cnt_reg <= 5'h00;
        blank_reg <= 1'b1;
        display_blank_out <= 1'b1;
    end else begin
        display_blank_out <= blank_reg | standby_reg;
        if (standby_reg) begin
            disp_cnt_reg <= 16'h0000;
            pair_cnt_reg <= 5'h00;
            blank_reg <= 1'b1;
        end else if (blank_reg) begin
            if (disp_cnt_reg == BLANK_CYCLES - 1) begin
                disp_cnt_reg <= 16'h0000;
                blank_reg <= 1'b0;
            end else begin
                disp_cnt_reg <= disp_cnt_reg + 16'h0001;
            end
        end else if (disp_cnt_reg == PAIR_CYCLES - 1) begin
            disp_cnt_reg <= 16'h0000;
            if (pair_cnt_reg + 5'h01 >= digit_pairs_out) begin
                pair_cnt_reg <= 5'h00;
                blank_reg <= 1'b1;
            end else begin
                pair_cnt_reg <= pair_cnt_reg + 5'h01;
            end
        end else begin
            disp_cnt_reg <= disp_cnt_reg + 16'h0001;
        end
    end
end

endmodule

/* File: src/vfk_regs.vh */
// Constants for the display controller key scan and serial port
// What this block does
// - Serial data out changes on each falling edge of the serial clock.
// - Serial data in is sampled on each rising edge of the serial clock.
// - Host holds select low for a whole transfer; device talks only then.
// - Serial data out is high impedance whenever select is high.
// - Standby output high puts grid driver in standby, low for normal use.
// - Row scanning starts only when a key press or release is seen.
// - After one full scan cycle whose key data differs from the stored data the key interrupt goes low.
// - Key interrupt stays low until the key data readout command runs.
// - Columns idle high; a low column means a pressed key.
// - Scanning repeats until the key data readout command has run; it stops after a cycle with no key change if no interrupt is pending.
// - All five rows go low when scanning stops.
// - One scan cycle of the key matrix takes 40 microseconds.
// - A key press in standby raises the interrupt within 5 or 10 ms.
// - A 10-bit dimming value applies to all displayed data.
// - Displayed digit pairs are programmable from one up to sixteen.
// - Every serial byte travels most significant bit first.
// - First byte after select falls is the command, later bytes are data.
// - Status byte is all zeros with new key data, all ones without.
// - Several key changes give a second interrupt after the first is read.
`ifndef VFK_REGS_VH
`define VFK_REGS_VH

// ********************************
// Timing
// ********************************
`define VFK_CLK_NS 20
`define VFK_SCAN_NS 40000
`define VFK_ROWS 5
`define VFK_COLS 6
`define VFK_OSC_NS 250
`define VFK_BLANK_OSC 48
`define VFK_PAIR_OSC 1024
`define VFK_SETTLE_CYC 4

// ********************************
// Commands and fields
// ********************************
`define VFK_CMD_READOUT 8'h10
`define VFK_CMD_NULL 8'h20
`define VFK_CMD_MODE 8'h30
`define VFK_CMD_DIM 8'h40
`define VFK_CMD_DIGITS 8'h50
`define VFK_MODE_STBY_BIT 0
`define VFK_STATUS_NEW 8'h00
`define VFK_STATUS_NONE 8'hff
`define VFK_RX_BYTES 6
`define VFK_DIM_RST 10'h3ff
`define VFK_DIGITS_RST 5'h10

`endif

/* File: src/vfk_sync.v */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module vfk_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // Data
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);

reg [W-1:0] meta_reg;

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        meta_reg <= RST_VAL;
        dout <= RST_VAL;
    end else begin
        meta_reg <= din;
        dout <= meta_reg;
    end
end

endmodule

/* File: tb/vfk_top_checker.sv */
// Assertion checker for the key scan and serial port
`timescale 1ns/1ps
module vfk_top_checker #(
    parameter ROW_CYCLES = 400
) (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // Serial port
    input wire sel_n,
    input wire sclk,
    input wire sdo_out,
    input wire sdo_oe,
    // Keys and grid driver
    input wire [4:0] key_row_out,
    input wire key_event_irq_n,
    input wire standby_out
);
    reg [4:0] rows_prev_reg;
    reg [15:0] dwell_reg;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // ****************************************
    // Row dwell counter
    // ****************************************
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rows_prev_reg <= 5'h00;
            dwell_reg <= 16'h0000;
        end else begin
            rows_prev_reg <= key_row_out;
            dwell_reg <= (key_row_out != rows_prev_reg) ? 16'h0001 : dwell_reg + 16'h0001;
        end
    end
    a_oe_off_idle: assert property (sel_n [*5] |-> !sdo_oe)
        else $error("serial out driven while deselected");
    a_oe_on_select: assert property ($fell(sel_n) |-> ##[2:6] sdo_oe)
        else $error("serial out not driven after select");
    a_sdo_hold_high: assert property ($rose(sclk) && !sel_n |-> ##2 $stable(sdo_out) [*3])
        else $error("serial out changed while clock high");
    a_irq_after_scan: assert property ($fell(key_event_irq_n) |-> key_row_out != 5'h00 && $past(key_row_out) != 5'h00)
        else $error("interrupt without scan");
    a_irq_held_low: assert property ($rose(key_event_irq_n) |-> sel_n && $past(sel_n, 2))
        else $error("interrupt released outside readout end");
    a_row_dwell_time: assert property (key_row_out != rows_prev_reg && key_row_out != 5'h00 && rows_prev_reg != 5'h00
        |-> dwell_reg == ROW_CYCLES)
        else $error("row dwell time wrong");
    a_reset_quiet_state: assert property ($rose(rstn) |-> !sdo_oe && key_event_irq_n && key_row_out == 5'h00)
        else $error("outputs active after reset");
    a_wake_on_select: assert property ($fell(sel_n) |-> ##[1:8] !standby_out)
        else $error("standby kept after select");
    c_irq_set: cover property ($fell(key_event_irq_n));
    c_irq_clear: cover property ($rose(key_event_irq_n));
    c_standby: cover property ($rose(standby_out));
endmodule
bind vfk_top vfk_top_checker #(.ROW_CYCLES(ROW_CYCLES)) u_chk (
    .clock(clock), .rstn(rstn), .sel_n(sel_n), .sclk(sclk), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .key_row_out(key_row_out), .key_event_irq_n(key_event_irq_n), .standby_out(standby_out)
);

/* File: tb/vfk_host_model.sv */
// Host serial master model driving select, clock and data
`timescale 1ns/1ps
module vfk_host_model (
    // Clock
    input wire clock,
    // Serial lines
    input wire somi,
    output reg sel_n,
    output reg sclk,
    output reg sdi
);
    initial begin
        sel_n = 1'b1;
        sclk = 1'b1;
        sdi = 1'b0;
    end
    task tick(input integer n);
        begin
            repeat (n) @(posedge clock);
            #1;
        end
    endtask
    task select;
        begin
            tick(1);
            sel_n = 1'b0;
            tick(6);
        end
    endtask
    task put_byte(input [7:0] tx, output [7:0] rx);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                sclk = 1'b0;
                sdi = tx[i];
                tick(4);
                sclk = 1'b1;
                tick(3);
                rx[i] = somi;
                tick(1);
            end
        end
    endtask
    task deselect;
        begin
            sdi = ~sdi;
            tick(3);
            sel_n = 1'b1;
            tick(10);
        end
    endtask
endmodule

/* File: tb/vf_display_keyscan_serial_port_tb_top.sv */
// Self-checking bench for the key scan and serial port
`timescale 1ns/1ps
`include "vfk_regs.vh"
module vf_display_keyscan_serial_port_tb_top;
    localparam ROWC = 10;
    reg clock = 1'b0;
    reg rstn = 1'b0;
    reg [29:0] keys = 30'h0;
    reg [5:0] cols;
    reg [7:0] txb [0:5];
    reg [7:0] rxb [0:5];
    integer err_count = 0;
    integer tests_run = 0;
    integer r, c;
    wire sel_n, sclk, sdi, sdo_out, sdo_oe, key_event_irq_n, standby_out, display_blank_out;
    wire [4:0] key_row_out, digit_pairs_out;
    wire [9:0] dim_value_out;
    wire somi = sdo_oe ? sdo_out : 1'bz;
    always #10 clock = ~clock;
    always @* begin
        cols = 6'h3f;
        for (r = 0; r < 5; r = r + 1)
            for (c = 0; c < 6; c = c + 1)
                if (keys[6 * r + c] && !key_row_out[r])
                    cols[c] = 1'b0;
    end
    vfk_top #(.ROW_CYCLES(ROWC), .PAIR_CYCLES(20), .BLANK_CYCLES(5)) u_dut (
        .clock(clock), .rstn(rstn), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo_out(sdo_out),
        .sdo_oe(sdo_oe), .key_column_in(cols), .key_row_out(key_row_out), .key_event_irq_n(key_event_irq_n),
        .standby_out(standby_out), .dim_value_out(dim_value_out), .digit_pairs_out(digit_pairs_out),
        .display_blank_out(display_blank_out)
    );
    vfk_host_model u_host (.clock(clock), .somi(somi), .sel_n(sel_n), .sclk(sclk), .sdi(sdi));
    task check(input string name, input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("[ERR] %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", tests_run, err_count);
            if (err_count == 0 && tests_run > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask
    task xfer(input [7:0] a, input [7:0] b, input [7:0] d, input integer n);
        integer i;
        begin
            txb[0] = a;
            txb[1] = b;
            txb[2] = d;
            for (i = 3; i < 6; i = i + 1)
                txb[i] = 8'h00;
            u_host.select;
            for (i = 0; i < n; i = i + 1)
                u_host.put_byte(txb[i], rxb[i]);
            u_host.deselect;
        end
    endtask
    task wait_irq;
        integer i;
        begin
            for (i = 0; i < 40 * ROWC && key_event_irq_n !== 1'b0; i = i + 1)
                u_host.tick(1);
            check("irq wait", key_event_irq_n, 0);
            if (key_event_irq_n !== 1'b0)
                conclude;
        end
    endtask
    task t_reset_idle;
        begin
            check("oe", sdo_oe, 0);
            check("irq", key_event_irq_n, 1);
            check("dim", dim_value_out, 32'h3ff);
            check("pairs", digit_pairs_out, 32'h10);
            xfer(`VFK_CMD_NULL, 8'h00, 8'h00, 3);
            check("status", rxb[0], 8'hff);
            check("row1", rxb[1], 8'h00);
            check("rows", key_row_out, 0);
            check("somi", somi, 1'bz);
            $display("reset and idle done");
        end
    endtask
    task t_key_readout;
        begin
            keys = 30'h1 << 8;
            wait_irq;
            check("scan", key_row_out != 5'h00, 1);
            xfer(`VFK_CMD_NULL, 8'h00, 8'h00, 3);
            check("status", rxb[0], 8'h00);
            check("row2", rxb[2], 8'h04);
            check("irq", key_event_irq_n, 0);
            xfer(`VFK_CMD_READOUT, 8'h00, 8'h00, 1);
            check("irq", key_event_irq_n, 1);
            u_host.tick(12 * ROWC);
            check("rows", key_row_out, 0);
            check("irq", key_event_irq_n, 1);
            $display("key readout done");
        end
    endtask
    task t_second_irq;
        begin
            keys = 30'h1 << 23;
            wait_irq;
            keys = 30'h0;
            u_host.tick(15 * ROWC);
            xfer(`VFK_CMD_NULL, 8'h00, 8'h00, 5);
            check("row4", rxb[4], 8'h20);
            xfer(`VFK_CMD_READOUT, 8'h00, 8'h00, 1);
            wait_irq;
            xfer(`VFK_CMD_READOUT, 8'h00, 8'h00, 5);
            check("row4", rxb[4], 8'h00);
            $display("second interrupt done");
        end
    endtask
    task t_standby;
        begin
            xfer(`VFK_CMD_MODE, 8'h01, 8'h00, 2);
            check("standby", standby_out, 1);
            keys = 30'h1;
            wait_irq;
            check("standby", standby_out, 0);
            xfer(`VFK_CMD_READOUT, 8'h00, 8'h00, 2);
            check("row1", rxb[1], 8'h01);
            keys = 30'h0;
            wait_irq;
            xfer(`VFK_CMD_READOUT, 8'h00, 8'h00, 1);
            xfer(`VFK_CMD_MODE, 8'h01, 8'h00, 2);
            xfer(`VFK_CMD_NULL, 8'h00, 8'h00, 1);
            check("standby", standby_out, 0);
            u_host.tick(12 * ROWC);
            check("irq", key_event_irq_n, 1);
            $display("standby done");
        end
    endtask
    task t_blanking;
        integer i, n;
        begin
            for (i = 0; i < 400 && display_blank_out !== 1'b0; i = i + 1)
                u_host.tick(1);
            for (i = 0; i < 400 && display_blank_out !== 1'b1; i = i + 1)
                u_host.tick(1);
            n = 0;
            for (i = 0; i < 50 && display_blank_out === 1'b1; i = i + 1) begin
                u_host.tick(1);
                n = n + 1;
            end
            check("blank", n, 5);
            $display("blanking done");
        end
    endtask
    task t_settings;
        begin
            xfer(`VFK_CMD_DIM, 8'h02, 8'h5a, 3);
            check("dim", dim_value_out, 32'h25a);
            check("status", rxb[2], 8'hff);
            xfer(`VFK_CMD_DIGITS, 8'h00, 8'h00, 2);
            check("pairs", digit_pairs_out, 1);
            xfer(`VFK_CMD_DIGITS, 8'h0f, 8'h00, 2);
            check("pairs", digit_pairs_out, 32'h10);
            $display("settings done");
        end
    endtask
    initial begin
        repeat (12) @(posedge clock);
        #1;
        rstn = 1'b1;
        u_host.tick(3);
        t_reset_idle;
        t_key_readout;
        t_second_irq;
        t_standby;
        t_settings;
        t_blanking;
        conclude;
    end
endmodule
